// ===== rtl/xat_core.sv
// Executes direction-load and exclusive-OR instructions against work and file registers
//
// Contract
// RQ1: Direction-load copies work register, flags untouched.
// RQ2: Operand 5/6/7 selects port A/B/C.
// RQ3: Literal XOR into work, zero flag only.
// RQ4: File XOR with 7-bit address, zero only.
// RQ5: Destination 0 writes work, file unchanged.
// RQ6: Destination 1 writes file, work unchanged.
// RQ7: Zero flag set iff XOR result zero.
`timescale 1ns/1ps
module xat_core import xat_pkg::*; (
    // Clock, enable, reset
    input wire logic clk,
    input wire logic ce,
    input wire logic rst_n,
    // Request
    input wire logic req_valid,
    input wire xat_req_t req,
    // Status
    output logic busy_ff,
    output logic done_ff,
    output logic illegal_ff,
    // Architectural state
    output logic [7:0] work_ff,
    output logic zero_ff,
    output logic [7:0] port_a_direction_ff,
    output logic [7:0] port_b_direction_ff,
    output logic [7:0] port_c_direction_ff,
    output logic [7:0] file_data_ff
);
    typedef enum logic {XAT_ST_IDLE, XAT_ST_FILE} xat_state_t;

    logic rst_meta_ff;
    logic rst_sync_n_ff;
    xat_state_t state_ff;
    xat_state_t nxt_state;
    logic [6:0] addr_ff;
    logic dest_ff;
    logic read_pend_ff;
    logic take;
    logic mem_we;
    logic [6:0] mem_waddr;
    logic [6:0] mem_raddr;
    logic [7:0] mem_wdata;
    logic [7:0] mem_rdata;
    logic [7:0] lit_result;
    logic [7:0] file_result;
    logic load_direction_from_work_ok;

    // Reset asserts at once, releases two edges later
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_ff <= 1'b0;
            rst_sync_n_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_n_ff <= rst_meta_ff;
        end
    end

    assign take = req_valid && !busy_ff && state_ff == XAT_ST_IDLE;
    assign lit_result = work_ff ^ req.operand; // RQ3
    assign file_result = work_ff ^ mem_rdata; // RQ4
    assign load_direction_from_work_ok = req.operand[2:0] == XAT_SEL_PORT_A || req.operand[2:0] == XAT_SEL_PORT_B
        || req.operand[2:0] == XAT_SEL_PORT_C; // RQ2
    // Only the low three bits are compared above; upper bits must also be zero
    logic load_direction_from_work_valid;
    assign load_direction_from_work_valid = load_direction_from_work_ok && req.operand[7:3] == 5'h00;

    // Single memory port pair; external load and write-back never overlap since busy blocks
    assign mem_we = (take && req.op == XAT_OP_LOAD_FILE)
        || (state_ff == XAT_ST_FILE && !read_pend_ff && dest_ff == XAT_DEST_FILE); // RQ6
    assign mem_waddr = state_ff == XAT_ST_FILE ? addr_ff : req.operand[6:0];
    assign mem_wdata = state_ff == XAT_ST_FILE ? file_result : req.operand;
    assign mem_raddr = take ? req.operand[6:0] : addr_ff; // RQ4

    xat_file_mem u_mem (
        .clk(clk),
        .ce(ce),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr(mem_raddr),
        .rdata_ff(mem_rdata)
    );

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            XAT_ST_IDLE: begin
                if (take && (req.op == XAT_OP_XOR_WORK_WITH_FILE || req.op == XAT_OP_READ_FILE)) begin
                    nxt_state = XAT_ST_FILE;
                end
            end
            XAT_ST_FILE: begin
                nxt_state = XAT_ST_IDLE;
            end
            default: begin
                nxt_state = XAT_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_sync_n_ff) begin
        if (!rst_sync_n_ff) begin
            state_ff <= XAT_ST_IDLE;
            busy_ff <= 1'b0;
            addr_ff <= 7'h00;
            dest_ff <= 1'b0;
            read_pend_ff <= 1'b0;
        end else if (ce) begin
            state_ff <= nxt_state;
            busy_ff <= nxt_state != XAT_ST_IDLE;
            if (take) begin
                addr_ff <= req.operand[6:0];
                dest_ff <= req.dest;
                read_pend_ff <= req.op == XAT_OP_READ_FILE;
            end
        end
    end

    // Completion and error pulses
    always_ff @(posedge clk or negedge rst_sync_n_ff) begin
        if (!rst_sync_n_ff) begin
            done_ff <= 1'b0;
            illegal_ff <= 1'b0;
        end else if (ce) begin
            done_ff <= (take && nxt_state == XAT_ST_IDLE) || state_ff == XAT_ST_FILE;
            illegal_ff <= take && req.op == XAT_OP_LOAD_DIRECTION_FROM_WORK && !load_direction_from_work_valid;
        end
    end

    // Work register and zero flag
    always_ff @(posedge clk or negedge rst_sync_n_ff) begin
        if (!rst_sync_n_ff) begin
            work_ff <= XAT_WORK_RESET;
            zero_ff <= XAT_ZERO_RESET;
        end else if (ce) begin
            if (take && req.op == XAT_OP_LOAD_WORK) begin
                work_ff <= req.operand;
            end else if (take && req.op == XAT_OP_XOR_LITERAL_INTO_WORK) begin
                work_ff <= lit_result; // RQ3
                zero_ff <= lit_result == 8'h00; // RQ7
            end else if (state_ff == XAT_ST_FILE && !read_pend_ff) begin
                if (dest_ff == XAT_DEST_WORK) begin
                    work_ff <= file_result; // RQ5
                end
                zero_ff <= file_result == 8'h00; // RQ7
            end
        end
    end

    // Direction registers; flags are deliberately not touched here
    always_ff @(posedge clk or negedge rst_sync_n_ff) begin
        if (!rst_sync_n_ff) begin
            port_a_direction_ff <= XAT_DIR_RESET;
            port_b_direction_ff <= XAT_DIR_RESET;
            port_c_direction_ff <= XAT_DIR_RESET;
        end else if (ce && take && req.op == XAT_OP_LOAD_DIRECTION_FROM_WORK && load_direction_from_work_valid) begin
            case (req.operand[2:0])
                XAT_SEL_PORT_A: port_a_direction_ff <= work_ff; // RQ1
                XAT_SEL_PORT_B: port_b_direction_ff <= work_ff; // RQ1
                XAT_SEL_PORT_C: port_c_direction_ff <= work_ff; // RQ1
                default: port_a_direction_ff <= port_a_direction_ff;
            endcase
        end
    end

    // Read-back of a file register for observation
    always_ff @(posedge clk or negedge rst_sync_n_ff) begin
        if (!rst_sync_n_ff) begin
            file_data_ff <= 8'h00;
        end else if (ce && state_ff == XAT_ST_FILE) begin
            file_data_ff <= read_pend_ff ? mem_rdata : file_result;
        end
    end

    a_dir_select: assert property (@(posedge clk) disable iff (!rst_sync_n_ff) // RQ2
        ce && take && req.op == XAT_OP_LOAD_DIRECTION_FROM_WORK && req.operand == 8'h06
        |=> port_b_direction_ff == $past(work_ff) && $stable(port_a_direction_ff)
            && $stable(port_c_direction_ff))
        else $error("port B direction not loaded from work");

    a_dir_flags: assert property (@(posedge clk) disable iff (!rst_sync_n_ff) // RQ1
        ce && take && req.op == XAT_OP_LOAD_DIRECTION_FROM_WORK
        |=> $stable(zero_ff) && $stable(work_ff))
        else $error("direction load disturbed work or zero flag");

    a_lit_xor: assert property (@(posedge clk) disable iff (!rst_sync_n_ff) // RQ3
        ce && take && req.op == XAT_OP_XOR_LITERAL_INTO_WORK
        |=> work_ff == ($past(work_ff) ^ $past(req.operand)) && done_ff)
        else $error("literal xor result wrong");

    a_file_xor_time: assert property (@(posedge clk) disable iff (!rst_sync_n_ff) // RQ4
        ce && take && req.op == XAT_OP_XOR_WORK_WITH_FILE
        |=> busy_ff && !done_ff ##1 (!$past(ce) || (done_ff && !busy_ff)))
        else $error("file xor did not complete one enabled cycle after busy");

    a_dest_work: assert property (@(posedge clk) disable iff (!rst_sync_n_ff) // RQ5
        ce && state_ff == XAT_ST_FILE && !read_pend_ff && dest_ff == XAT_DEST_WORK
        |-> !mem_we ##1 work_ff == $past(file_result))
        else $error("destination work handling wrong");

    a_dest_file: assert property (@(posedge clk) disable iff (!rst_sync_n_ff) // RQ6
        ce && state_ff == XAT_ST_FILE && !read_pend_ff && dest_ff == XAT_DEST_FILE
        |-> mem_we && mem_waddr == addr_ff ##1 $stable(work_ff))
        else $error("destination file handling wrong");

    a_zero_flag: assert property (@(posedge clk) disable iff (!rst_sync_n_ff) // RQ7
        ce && ((take && req.op == XAT_OP_XOR_LITERAL_INTO_WORK)
            || (state_ff == XAT_ST_FILE && !read_pend_ff))
        |=> zero_ff == ($past(take) ? $past(lit_result) == 8'h00 : $past(file_result) == 8'h00))
        else $error("zero flag does not match xor result");

    a_bad_select: assert property (@(posedge clk) disable iff (!rst_sync_n_ff) // RQ2
        ce && take && req.op == XAT_OP_LOAD_DIRECTION_FROM_WORK && req.operand == 8'h04
        |=> illegal_ff && $stable(port_a_direction_ff) && $stable(port_b_direction_ff))
        else $error("invalid direction select not refused");
endmodule

// ===== rtl/xat_pkg.sv
// Package: operations, request layout and reset values for the XOR and direction-load block
package xat_pkg;
    localparam int XAT_DATA_W = 8;
    localparam int XAT_ADDR_W = 7;
    localparam int XAT_FILE_DEPTH = 128;
    localparam int XAT_LOAD_DIRECTION_FROM_WORK_SEL_W = 3;
    localparam logic [2:0] XAT_SEL_PORT_A = 3'h5;
    localparam logic [2:0] XAT_SEL_PORT_B = 3'h6;
    localparam logic [2:0] XAT_SEL_PORT_C = 3'h7;
    localparam logic [7:0] XAT_DIR_RESET = 8'hff;
    localparam logic [7:0] XAT_WORK_RESET = 8'h00;
    localparam logic XAT_ZERO_RESET = 1'b0;
    localparam logic XAT_DEST_WORK = 1'b0;
    localparam logic XAT_DEST_FILE = 1'b1;

    typedef enum logic [2:0] {
        XAT_OP_LOAD_WORK,
        XAT_OP_LOAD_FILE,
        XAT_OP_READ_FILE,
        XAT_OP_LOAD_DIRECTION_FROM_WORK,
        XAT_OP_XOR_LITERAL_INTO_WORK,
        XAT_OP_XOR_WORK_WITH_FILE
    } xat_op_t;

    typedef struct packed {
        xat_op_t op;
        logic [7:0] operand;
        logic dest;
    } xat_req_t;
endpackage

// ===== rtl/xat_file_mem.sv
// File register memory: one write port, one registered read port
`timescale 1ns/1ps
module xat_file_mem import xat_pkg::*; (
    // Clock
    input wire logic clk,
    input wire logic ce,
    // Write port
    input wire logic we,
    input wire logic [XAT_ADDR_W-1:0] waddr,
    input wire logic [XAT_DATA_W-1:0] wdata,
    // Read port
    input wire logic [XAT_ADDR_W-1:0] raddr,
    output logic [XAT_DATA_W-1:0] rdata_ff
);
    logic [XAT_DATA_W-1:0] mem [XAT_FILE_DEPTH];

    // No reset so it maps onto RAM; contents undefined until written
    always_ff @(posedge clk) begin
        if (ce && we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (ce) begin
            rdata_ff <= mem[raddr];
        end
    end
endmodule

// ===== bench/tb_xor_and_load_direction_from_work_load_ops.sv
// Self-checking testbench for the XOR and direction-load block
`timescale 1ns/1ps
module tb_xor_and_load_direction_from_work_load_ops import xat_pkg::*;;
    // Clock, enable, reset
    logic clk;
    logic ce;
    logic rst_n;
    // Request
    logic req_valid;
    xat_req_t req;
    // Observed outputs
    logic busy_ff;
    logic done_ff;
    logic illegal_ff;
    logic [7:0] work_ff;
    logic zero_ff;
    logic [7:0] pa_ff;
    logic [7:0] pb_ff;
    logic [7:0] pc_ff;
    logic [7:0] file_data_ff;
    int miscompares;
    int total_checks;
    logic [7:0] exp_dir [3];

    xat_core u_dut (.clk(clk), .ce(ce), .rst_n(rst_n), .req_valid(req_valid), .req(req),
        .busy_ff(busy_ff), .done_ff(done_ff), .illegal_ff(illegal_ff), .work_ff(work_ff),
        .zero_ff(zero_ff), .port_a_direction_ff(pa_ff), .port_b_direction_ff(pb_ff),
        .port_c_direction_ff(pc_ff), .file_data_ff(file_data_ff));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic tally_and_finish();
        if (miscompares == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic chk_dirs();
        chk_byte(pa_ff, exp_dir[0], "port a dir");
        chk_byte(pb_ff, exp_dir[1], "port b dir");
        chk_byte(pc_ff, exp_dir[2], "port c dir");
    endtask

    // Valid stays up between calls so back-to-back issue never lowers and raises it at once
    task automatic issue(input xat_op_t o, input logic [7:0] k, input logic d);
        int n;
        n = 0;
        req_valid = 1'b1;
        req = '{op: o, operand: k, dest: d};
        @(posedge clk);
        #1;
        while (done_ff !== 1'b1 && n < 6) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (done_ff !== 1'b1) begin
            miscompares++;
            $display("mismatch at %0t: no completion", $time);
            tally_and_finish();
        end
    endtask

    task automatic t_direction();
        logic [7:0] sel;
        issue(XAT_OP_LOAD_WORK, 8'h00, 1'b0);
        issue(XAT_OP_XOR_LITERAL_INTO_WORK, 8'h00, 1'b0);
        for (int i = 0; i < 3; i++) begin
            sel = 8'h05 + 8'(i);
            issue(XAT_OP_LOAD_WORK, 8'h31 + 8'(i), 1'b0);
            issue(XAT_OP_LOAD_DIRECTION_FROM_WORK, sel, 1'b0);
            exp_dir[i] = 8'h31 + 8'(i);
            chk_dirs();
            chk_bit(illegal_ff, 1'b0, "illegal on good select");
            chk_bit(zero_ff, 1'b1, "zero kept");
        end
        issue(XAT_OP_LOAD_WORK, 8'haa, 1'b0);
        for (int j = 0; j < 2; j++) begin
            sel = (j == 0) ? 8'h04 : 8'h0d;
            issue(XAT_OP_LOAD_DIRECTION_FROM_WORK, sel, 1'b0);
            chk_bit(illegal_ff, 1'b1, "illegal on bad select");
            chk_dirs();
        end
    endtask

    task automatic t_literal();
        issue(XAT_OP_LOAD_WORK, 8'h3c, 1'b0);
        issue(XAT_OP_XOR_LITERAL_INTO_WORK, 8'hc3, 1'b0);
        chk_byte(work_ff, 8'hff, "literal xor");
        chk_bit(zero_ff, 1'b0, "zero clear");
        issue(XAT_OP_XOR_LITERAL_INTO_WORK, 8'hff, 1'b0);
        chk_byte(work_ff, 8'h00, "literal xor to zero");
        chk_bit(zero_ff, 1'b1, "zero set");
        issue(XAT_OP_XOR_LITERAL_INTO_WORK, 8'h80, 1'b0);
        chk_bit(zero_ff, 1'b0, "zero clear msb");
        chk_dirs();
    endtask

    task automatic t_file();
        issue(XAT_OP_LOAD_FILE, 8'h55, 1'b0);
        issue(XAT_OP_LOAD_FILE, 8'h7f, 1'b0);
        issue(XAT_OP_LOAD_WORK, 8'h0f, 1'b0);
        issue(XAT_OP_XOR_WORK_WITH_FILE, 8'h55, XAT_DEST_WORK);
        chk_byte(work_ff, 8'h5a, "file xor to work");
        chk_bit(zero_ff, 1'b0, "zero file xor");
        issue(XAT_OP_READ_FILE, 8'h55, 1'b0);
        chk_byte(file_data_ff, 8'h55, "file untouched");
        issue(XAT_OP_XOR_WORK_WITH_FILE, 8'h55, XAT_DEST_FILE);
        chk_byte(work_ff, 8'h5a, "work kept");
        chk_byte(file_data_ff, 8'h0f, "xor result");
        issue(XAT_OP_READ_FILE, 8'h55, 1'b0);
        chk_byte(file_data_ff, 8'h0f, "file written");
        issue(XAT_OP_LOAD_WORK, 8'h7f, 1'b0);
        issue(XAT_OP_XOR_WORK_WITH_FILE, 8'h7f, XAT_DEST_FILE);
        chk_bit(zero_ff, 1'b1, "zero top address");
        issue(XAT_OP_READ_FILE, 8'h7f, 1'b0);
        chk_byte(file_data_ff, 8'h00, "top address");
        issue(XAT_OP_XOR_WORK_WITH_FILE, 8'h7f, XAT_DEST_WORK);
        chk_byte(work_ff, 8'h7f, "xor with zero");
        chk_bit(zero_ff, 1'b0, "zero cleared");
        chk_dirs();
    endtask

    // Freeze with ce low, then a file xor watched cycle by cycle; work is 7f on entry
    task automatic t_hold();
        ce = 1'b0;
        req = '{op: XAT_OP_XOR_LITERAL_INTO_WORK, operand: 8'hff, dest: 1'b0};
        repeat (3) @(posedge clk);
        #1;
        chk_byte(work_ff, 8'h7f, "work frozen");
        chk_bit(zero_ff, 1'b0, "zero frozen");
        ce = 1'b1;
        issue(XAT_OP_XOR_LITERAL_INTO_WORK, 8'hff, 1'b0);
        chk_byte(work_ff, 8'h80, "xor after freeze");
        req = '{op: XAT_OP_XOR_WORK_WITH_FILE, operand: 8'h55, dest: XAT_DEST_WORK};
        @(posedge clk);
        #1;
        chk_bit(busy_ff, 1'b1, "busy mid file xor");
        chk_bit(done_ff, 1'b0, "done mid file xor");
        @(posedge clk);
        #1;
        chk_bit(busy_ff, 1'b0, "busy after file xor");
        chk_bit(done_ff, 1'b1, "done after file xor");
        chk_byte(work_ff, 8'h8f, "file xor after freeze");
        chk_bit(zero_ff, 1'b0, "zero after file xor");
    endtask

    initial begin
        miscompares = 0;
        total_checks = 0;
        rst_n = 1'b0;
        ce = 1'b1;
        req_valid = 1'b0;
        req = '0;
        exp_dir = '{XAT_DIR_RESET, XAT_DIR_RESET, XAT_DIR_RESET};
        repeat (12) @(posedge clk);
        #1;
        rst_n = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk_dirs();
        chk_byte(work_ff, XAT_WORK_RESET, "work reset");
        chk_bit(zero_ff, XAT_ZERO_RESET, "zero reset");
        chk_bit(busy_ff, 1'b0, "busy reset");
        chk_bit(done_ff, 1'b0, "done reset");
        chk_bit(illegal_ff, 1'b0, "illegal reset");
        chk_byte(file_data_ff, 8'h00, "file data reset");
        t_direction();
        t_literal();
        t_file();
        t_hold();
        req_valid = 1'b0;
        repeat (2) @(posedge clk);
        tally_and_finish();
    end
endmodule
